// file: rtl/ssd_decoder.v
/*
 Decoder and sequencer for set-byte, logical and double shifts, table
 stores and software management entry.
 Assumes the fetch unit presents one instruction byte per cycle with a
 valid strobe and holds it while byte_ready is low; flags come from the
 core flag register on the same clock.
*/
// Operation
// - 0F 9F /0 set_byte_if_negative byte if greater, one cycle
// - 0F 91 /0 set_byte_if_negative byte if no overflow, one cycle
// - 0F 9B /0 set_byte_if_negative byte if parity odd, one cycle
// - 0F 99 /0 set_byte_if_negative byte if not negative, one cycle
// - 0F 90 /0 set_byte_if_negative byte if overflow, one cycle
// - 0F 9A /0 set_byte_if_negative byte if parity even, one cycle
// - 0F 98 /0 set_byte_if_negative byte if negative, one cycle
// - 0F 01 /0 stores global table register, four cycles
// - Left shift /4: by one or immediate one cycle, by count two
// - Double left shift: A4 immediate four cycles, A5 count five
// - Right shift /5 with same encodings, costs and flags as left
// - Double right shift: AC immediate four cycles, AD count five
// - 0F 01 /1 stores interrupt table register, four cycles
// - 0F 00 /0 stores local table register, protected mode only
// - 0F 38 enters management mode, 55 cycles
// - Immediate shift forms fetch one 8-bit count after selector
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_decoder (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Instruction byte stream
    input wire byte_valid,
    input wire [7:0] byte_data,
    output wire byte_ready,
    // Core state
    input wire prot_mode,
    input wire [7:0] count_low_register,
    input wire overflow_flag,
    input wire sign_flag,
    input wire zero_flag,
    input wire parity_flag,
    // Decoded operation
    output reg op_start_q,
    output reg op_done_q,
    output reg [3:0] op_kind_q,
    output reg [7:0] op_opcode_q,
    output reg [1:0] op_mod_q,
    output reg [2:0] op_reg_q,
    output reg [2:0] op_rm_q,
    output reg op_wide_q,
    output reg [7:0] op_count_q,
    output reg [5:0] op_cycles_q,
    output reg op_illegal_q,
    // Set-byte result, flag control and management entry
    output reg [7:0] set_value_q,
    output reg flags_write_q,
    output reg overflow_undef_q,
    output reg aux_carry_undef_q,
    output reg mgmt_entry_q
);

// ============================================================
// States
localparam ST_OP = 3'h0;
localparam ST_OP2 = 3'h1;
localparam ST_MODRM = 3'h2;
localparam ST_IMM = 3'h3;
localparam ST_EXEC = 3'h4;

reg [2:0] st_q;
reg [7:0] opc_q;
reg esc_q;
reg [7:0] modrm_q;
reg [5:0] busy_q;
// Immediate count kept apart so op_count_q only moves at issue
reg [7:0] imm_q;

// ============================================================
// Byte handshake
// Stream stalls for the whole latency; operations never overlap
assign byte_ready = (st_q != ST_EXEC);

// ============================================================
// Helpers
// Condition of a set-byte opcode from the flags sampled at issue
function set_cond;
    input [7:0] op;
    input ovf, sgn, zro, par;
    begin
        case (op)
            `SSD_OP_SET_GREATER: set_cond = ~zro & (sgn == ovf);
            `SSD_OP_SET_NO_OVF: set_cond = ~ovf;
            `SSD_OP_SET_PAR_ODD: set_cond = ~par;
            `SSD_OP_SET_NOT_NEG: set_cond = ~sgn;
            `SSD_OP_SET_OVF: set_cond = ovf;
            `SSD_OP_SET_PAR_EVEN: set_cond = par;
            `SSD_OP_SET_NEG: set_cond = sgn;
            default: set_cond = 1'b0;
        endcase
    end
endfunction

// Set-byte family, all with subfield 000
function is_setcc;
    input [7:0] op;
    begin
        is_setcc = (op == `SSD_OP_SET_GREATER) || (op == `SSD_OP_SET_NO_OVF) ||
            (op == `SSD_OP_SET_PAR_ODD) || (op == `SSD_OP_SET_NOT_NEG) ||
            (op == `SSD_OP_SET_OVF) || (op == `SSD_OP_SET_PAR_EVEN) ||
            (op == `SSD_OP_SET_NEG);
    end
endfunction

// Escaped opcodes that carry an operand selector byte
function esc_has_modrm;
    input [7:0] op;
    begin
        esc_has_modrm = is_setcc(op) || (op == `SSD_OP_GRP_TBL) ||
            (op == `SSD_OP_GRP_LDT) || (op == `SSD_OP_DSHL_IMM) ||
            (op == `SSD_OP_DSHL_CNT) || (op == `SSD_OP_DSHR_IMM) ||
            (op == `SSD_OP_DSHR_CNT);
    end
endfunction

// First bytes D0-D3 and C0-C1 open a one-byte logical shift
function one_byte_shift;
    input [7:0] op;
    begin
        one_byte_shift = (op[7:1] == `SSD_OP_SH_ONE_HI) ||
            (op[7:1] == `SSD_OP_SH_CNT_HI) || (op[7:1] == `SSD_OP_SH_IMM_HI);
    end
endfunction

// Forms that carry an 8-bit count byte after the selector
function needs_imm;
    input esc;
    input [7:0] op;
    begin
        needs_imm = esc ? ((op == `SSD_OP_DSHL_IMM) || (op == `SSD_OP_DSHR_IMM))
            : (op[7:1] == `SSD_OP_SH_IMM_HI);
    end
endfunction

// ============================================================
// Classification of a complete instruction
reg [3:0] kind_c;
reg [5:0] cyc_c;
reg ovf_u_c;
reg aux_u_c;
reg flw_c;
reg [7:0] cnt_c;
reg ill_c;
always @* begin
    kind_c = `SSD_K_NONE;
    cyc_c = `SSD_CYC_1;
    ovf_u_c = 1'b0;
    aux_u_c = 1'b0;
    flw_c = 1'b0;
    cnt_c = 8'h00;
    ill_c = 1'b0;
    if (esc_q) begin
        if (opc_q == `SSD_OP_SMM_ENTRY) begin
            kind_c = `SSD_K_SMM;
            cyc_c = `SSD_CYC_55;
        end else if (is_setcc(opc_q)) begin
            kind_c = `SSD_K_SETCC;
            cyc_c = `SSD_CYC_1;
            ill_c = (modrm_q[5:3] != `SSD_SUB_000);
        end else if (opc_q == `SSD_OP_GRP_TBL) begin
            if (modrm_q[5:3] == `SSD_SUB_000) begin
                kind_c = `SSD_K_STORE_GLOBAL_TABLE_REG;
                cyc_c = `SSD_CYC_4;
            end else if (modrm_q[5:3] == `SSD_SUB_001) begin
                kind_c = `SSD_K_STORE_INTERRUPT_TABLE_REG;
                cyc_c = `SSD_CYC_4;
            end else begin
                ill_c = 1'b1;
            end
        end else if (opc_q == `SSD_OP_GRP_LDT) begin
            // No real-mode timing exists, so real mode faults it
            kind_c = `SSD_K_STORE_LOCAL_TABLE_REG;
            cyc_c = `SSD_CYC_1;
            ill_c = ~prot_mode || (modrm_q[5:3] != `SSD_SUB_000);
        end else if ((opc_q == `SSD_OP_DSHL_IMM) || (opc_q == `SSD_OP_DSHL_CNT)) begin
            kind_c = `SSD_K_DSHL;
            cyc_c = opc_q[0] ? `SSD_CYC_5 : `SSD_CYC_4;
            // Count register as it stands at issue, unmasked
            cnt_c = opc_q[0] ? count_low_register : imm_q;
            ovf_u_c = 1'b1;
            aux_u_c = 1'b1;
            flw_c = 1'b1;
        end else if ((opc_q == `SSD_OP_DSHR_IMM) || (opc_q == `SSD_OP_DSHR_CNT)) begin
            kind_c = `SSD_K_DSHR;
            cyc_c = opc_q[0] ? `SSD_CYC_5 : `SSD_CYC_4;
            // Count register as it stands at issue, unmasked
            cnt_c = opc_q[0] ? count_low_register : imm_q;
            ovf_u_c = 1'b1;
            aux_u_c = 1'b1;
            flw_c = 1'b1;
        end else begin
            ill_c = 1'b1;
        end
    end else if ((modrm_q[5:3] == `SSD_SUB_SHL) || (modrm_q[5:3] == `SSD_SUB_SHR)) begin
        // Only subfields 100 and 101 of the one-byte shifts are handled
        kind_c = (modrm_q[5:3] == `SSD_SUB_SHL) ? `SSD_K_SHL : `SSD_K_SHR;
        flw_c = 1'b1;
        aux_u_c = 1'b1;
        if (opc_q[7:1] == `SSD_OP_SH_CNT_HI) begin
            cyc_c = `SSD_CYC_2;
            cnt_c = count_low_register;
            ovf_u_c = 1'b1;
        end else if (opc_q[7:1] == `SSD_OP_SH_IMM_HI) begin
            cyc_c = `SSD_CYC_1;
            cnt_c = imm_q;
            ovf_u_c = 1'b1;
        end else begin
            cyc_c = `SSD_CYC_1;
            cnt_c = 8'h01;
        end
    end else begin
        ill_c = 1'b1;
    end
end

// ============================================================
// Sequencer
// One instruction in flight; the stream stalls until done
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        st_q <= ST_OP;
        opc_q <= 8'h00;
        esc_q <= 1'b0;
        modrm_q <= 8'h00;
        busy_q <= 6'h00;
        imm_q <= 8'h00;
        op_start_q <= 1'b0;
        op_done_q <= 1'b0;
        op_kind_q <= `SSD_K_NONE;
        op_opcode_q <= 8'h00;
        op_mod_q <= 2'h0;
        op_reg_q <= 3'h0;
        op_rm_q <= 3'h0;
        op_wide_q <= 1'b0;
        op_count_q <= 8'h00;
        op_cycles_q <= 6'h00;
        op_illegal_q <= 1'b0;
        set_value_q <= `SSD_SET_FALSE;
        flags_write_q <= 1'b0;
        overflow_undef_q <= 1'b0;
        aux_carry_undef_q <= 1'b0;
        mgmt_entry_q <= 1'b0;
    end else begin
        op_start_q <= 1'b0;
        op_done_q <= 1'b0;
        op_illegal_q <= 1'b0;
        case (st_q)
            ST_OP: begin
                if (byte_valid) begin
                    if (byte_data == `SSD_ESC_0F) begin
                        esc_q <= 1'b1;
                        st_q <= ST_OP2;
                    end else if (one_byte_shift(byte_data)) begin
                        esc_q <= 1'b0;
                        opc_q <= byte_data;
                        st_q <= ST_MODRM;
                    end else begin
                        // Outside this decoder's set
                        op_illegal_q <= 1'b1;
                    end
                end
            end
            ST_OP2: begin
                if (byte_valid) begin
                    opc_q <= byte_data;
                    if (byte_data == `SSD_OP_SMM_ENTRY) begin
                        // No selector byte follows; stale fields must not issue
                        modrm_q <= 8'h00;
                        st_q <= ST_EXEC;
                    end else if (esc_has_modrm(byte_data)) begin
                        st_q <= ST_MODRM;
                    end else begin
                        op_illegal_q <= 1'b1;
                        st_q <= ST_OP;
                    end
                end
            end
            ST_MODRM: begin
                if (byte_valid) begin
                    modrm_q <= byte_data;
                    st_q <= needs_imm(esc_q, opc_q) ? ST_IMM : ST_EXEC;
                end
            end
            ST_IMM: begin
                if (byte_valid) begin
                    imm_q <= byte_data;
                    st_q <= ST_EXEC;
                end
            end
            default: begin
                // Issue on entry, then count down the documented latency
                if (busy_q == 6'h00) begin
                    if (ill_c) begin
                        op_illegal_q <= 1'b1;
                        st_q <= ST_OP;
                    end else begin
                        op_start_q <= 1'b1;
                        op_kind_q <= kind_c;
                        op_opcode_q <= opc_q;
                        op_mod_q <= modrm_q[7:6];
                        op_reg_q <= modrm_q[5:3];
                        op_rm_q <= modrm_q[2:0];
                        op_wide_q <= opc_q[0];
                        op_count_q <= cnt_c;
                        op_cycles_q <= cyc_c;
                        flags_write_q <= flw_c;
                        overflow_undef_q <= ovf_u_c;
                        aux_carry_undef_q <= aux_u_c;
                        set_value_q <= set_cond(opc_q, overflow_flag, sign_flag,
                            zero_flag, parity_flag) ? `SSD_SET_TRUE : `SSD_SET_FALSE;
                        mgmt_entry_q <= (kind_c == `SSD_K_SMM);
                        if (cyc_c == `SSD_CYC_1) begin
                            op_done_q <= 1'b1;
                            st_q <= ST_OP;
                        end else begin
                            busy_q <= cyc_c - 6'h01;
                        end
                    end
                end else begin
                    busy_q <= busy_q - 6'h01;
                    // Entry flag drops on the same edge as the done pulse
                    if (busy_q == 6'h01) begin
                        op_done_q <= 1'b1;
                        mgmt_entry_q <= 1'b0;
                        st_q <= ST_OP;
                    end
                end
            end
        endcase
    end
end

endmodule // ssd_decoder

// file: rtl/ssd_defs.vh
/*
 Constants for the shift, set-byte and table-store decoder.
 Included by rtl/ssd_decoder.v; definitions only.
*/
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH
`define SSD_ESC_0F 8'h0f
`define SSD_OP_SET_NO_OVF 8'h91
`define SSD_OP_SET_OVF 8'h90
`define SSD_OP_SET_NEG 8'h98
`define SSD_OP_SET_NOT_NEG 8'h99
`define SSD_OP_SET_PAR_EVEN 8'h9a
`define SSD_OP_SET_PAR_ODD 8'h9b
`define SSD_OP_SET_GREATER 8'h9f
`define SSD_OP_GRP_TBL 8'h01
`define SSD_OP_GRP_LDT 8'h00
`define SSD_OP_DSHL_IMM 8'ha4
`define SSD_OP_DSHL_CNT 8'ha5
`define SSD_OP_DSHR_IMM 8'hac
`define SSD_OP_DSHR_CNT 8'had
`define SSD_OP_SMM_ENTRY 8'h38
`define SSD_OP_SH_ONE_HI 7'h68
`define SSD_OP_SH_CNT_HI 7'h69
`define SSD_OP_SH_IMM_HI 7'h60
`define SSD_SUB_000 3'h0
`define SSD_SUB_001 3'h1
`define SSD_SUB_SHL 3'h4
`define SSD_SUB_SHR 3'h5
`define SSD_CYC_1 6'h01
`define SSD_CYC_2 6'h02
`define SSD_CYC_4 6'h04
`define SSD_CYC_5 6'h05
`define SSD_CYC_55 6'h37
`define SSD_SET_TRUE 8'h01
`define SSD_SET_FALSE 8'h00
`define SSD_K_NONE 4'h0
`define SSD_K_SETCC 4'h1
`define SSD_K_STORE_GLOBAL_TABLE_REG 4'h2
`define SSD_K_STORE_INTERRUPT_TABLE_REG 4'h3
`define SSD_K_STORE_LOCAL_TABLE_REG 4'h4
`define SSD_K_SHL 4'h5
`define SSD_K_SHR 4'h6
`define SSD_K_DSHL 4'h7
`define SSD_K_DSHR 4'h8
`define SSD_K_SMM 4'h9
`endif

// file: verif/ssd_checker_assertions.sv
/*
 Assertions on issue and completion timing of the decoder.
 Bound into ssd_decoder; sees its ports only, one clock domain.
*/
`timescale 1ns/1ps
module ssd_checker (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Stream and mode at the pins
    input wire byte_ready,
    input wire prot_mode,
    // Decoder outputs
    input wire op_start_q,
    input wire op_done_q,
    input wire [3:0] op_kind_q,
    input wire [7:0] op_opcode_q,
    input wire [7:0] op_count_q,
    input wire [5:0] op_cycles_q,
    input wire op_illegal_q,
    input wire [7:0] set_value_q,
    input wire flags_write_q,
    input wire overflow_undef_q,
    input wire aux_carry_undef_q,
    input wire mgmt_entry_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ==========
    // Properties
    property p_one;
        op_start_q && op_cycles_q == 6'h01 |-> op_done_q;
    endproperty
    property p_set;
        op_start_q && op_kind_q == 4'h1 |-> !flags_write_q && set_value_q[7:1] == 7'h00;
    endproperty
    property p_sh_one;
        op_start_q && op_opcode_q[7:1] == 7'h68 && op_kind_q inside {4'h5, 4'h6}
            |-> op_count_q == 8'h01 && !overflow_undef_q && aux_carry_undef_q;
    endproperty
    property p_sh_cnt;
        op_start_q && op_opcode_q[7:1] == 7'h69 && op_kind_q inside {4'h5, 4'h6}
            |-> op_cycles_q == 6'h02 && !op_done_q ##1 op_done_q;
    endproperty
    property p_tbl;
        op_start_q && op_kind_q inside {4'h2, 4'h3}
            |-> op_cycles_q == 6'h04 && !op_done_q ##1 !op_done_q [*2] ##1 op_done_q;
    endproperty
    property p_dsh;
        op_start_q && op_kind_q inside {4'h7, 4'h8} |-> overflow_undef_q
            && aux_carry_undef_q && op_cycles_q == (op_opcode_q[0] ? 6'h05 : 6'h04);
    endproperty
    property p_dsh_lat;
        op_start_q && op_opcode_q == 8'ha5 |-> !op_done_q [*4] ##1 op_done_q;
    endproperty
    property p_ldt;
        op_start_q && op_kind_q == 4'h4
            |-> op_done_q && op_cycles_q == 6'h01 && $past(prot_mode);
    endproperty
    property p_bad;
        op_illegal_q |-> !op_start_q && !mgmt_entry_q;
    endproperty
    property p_smm;
        op_start_q && op_kind_q == 4'h9 |-> mgmt_entry_q && op_cycles_q == 6'h37 ##54 op_done_q;
    endproperty
    property p_busy;
        mgmt_entry_q |-> !byte_ready;
    endproperty
    // ==========
    // Assertions
    a_one: assert property (p_one) else $error("one-cycle op not done at issue");
    a_set: assert property (p_set) else $error("set-byte value or flags wrong");
    a_sh_one: assert property (p_sh_one) else $error("shift by one wrong");
    a_sh_cnt: assert property (p_sh_cnt) else $error("count shift not two cycles");
    a_tbl: assert property (p_tbl) else $error("table store not four cycles");
    a_dsh: assert property (p_dsh) else $error("double shift cost or flags wrong");
    a_dsh_lat: assert property (p_dsh_lat) else $error("double shift latency");
    a_ldt: assert property (p_ldt) else $error("local table store wrong");
    a_bad: assert property (p_bad) else $error("refused op still issued");
    a_smm: assert property (p_smm) else $error("management entry timing wrong");
    a_busy: assert property (p_busy) else $error("stream open during entry");
    // ==========
    // Coverage
    c_set: cover property (op_start_q && op_kind_q == 4'h1);
    c_smm: cover property (op_start_q && op_kind_q == 4'h9);
    c_bad: cover property (op_illegal_q);
    c_dsh: cover property (op_start_q && op_opcode_q == 8'had);
endmodule // ssd_checker

bind ssd_decoder ssd_checker i_ssd_checker (.clk_sys, .rst, .byte_ready, .prot_mode,
    .op_start_q, .op_done_q,
    .op_kind_q, .op_opcode_q, .op_count_q, .op_cycles_q, .op_illegal_q, .set_value_q,
    .flags_write_q, .overflow_undef_q, .aux_carry_undef_q, .mgmt_entry_q);

// file: verif/ssd_decoder_bench.sv
/*
 Self-checking bench for ssd_decoder.
 Inputs change on the falling edge; no partner model.
*/
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_decoder_bench;
    reg clk_sys, rst, byte_valid, prot_mode, mg0;
    reg overflow_flag, sign_flag, zero_flag, parity_flag;
    reg [7:0] byte_data, count_low_register;
    wire byte_ready, op_start_q, op_done_q, op_wide_q, op_illegal_q;
    wire flags_write_q, overflow_undef_q, aux_carry_undef_q, mgmt_entry_q;
    wire [3:0] op_kind_q;
    wire [7:0] op_opcode_q, op_count_q, set_value_q;
    wire [1:0] op_mod_q;
    wire [2:0] op_reg_q, op_rm_q;
    wire [5:0] op_cycles_q;
    int mismatches, compares;

    ssd_decoder i_ssd_decoder (.clk_sys, .rst, .byte_valid, .byte_data, .byte_ready,
        .prot_mode, .count_low_register, .overflow_flag, .sign_flag, .zero_flag,
        .parity_flag, .op_start_q, .op_done_q, .op_kind_q, .op_opcode_q, .op_mod_q,
        .op_reg_q, .op_rm_q, .op_wide_q, .op_count_q, .op_cycles_q, .op_illegal_q,
        .set_value_q, .flags_write_q, .overflow_undef_q, .aux_carry_undef_q, .mgmt_entry_q);

    // ==========
    // Helpers
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task hang;
        chk("wait bound", 8'h00, 8'h01);
        stop_test;
    endtask
    // Valid stays up between bytes so it is never driven twice in one step
    task send(input [7:0] b);
        int i;
        byte_valid = 1'b1;
        byte_data = b;
        for (i = 0; byte_ready !== 1'b1; i++) begin
            if (i == 200) hang;
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
    endtask
    // Latency measured from the start pulse to the done pulse
    task run(input [3:0] k, input [5:0] cyc);
        reg [7:0] n;
        byte_valid = 1'b0;
        chk("ready", {7'h0, byte_ready}, 8'h00);
        for (n = 0; op_start_q !== 1'b1; n++) begin
            if (n == 8) hang;
            @(negedge clk_sys);
        end
        mg0 = mgmt_entry_q;
        for (n = 1; op_done_q !== 1'b1; n++) begin
            if (n == 80) hang;
            @(negedge clk_sys);
        end
        chk("kind", {4'h0, op_kind_q}, {4'h0, k});
        chk("cycles", {2'h0, op_cycles_q}, {2'h0, cyc});
        chk("latency", n, {2'h0, cyc});
    endtask

    // ==========
    // Scenarios
    task t_setcc;
        reg [7:0] op;
        reg e;
        int m, f;
        for (m = 0; m < 2; m++)
            for (f = 0; f < 16; f++)
                for (op = 8'h90; op < 8'ha0; op++) begin
                    prot_mode = m[0];
                    {overflow_flag, sign_flag, zero_flag, parity_flag} = f[3:0];
                    case (op)
                        8'h9f: e = !zero_flag && (sign_flag == overflow_flag);
                        8'h91: e = !overflow_flag;
                        8'h9b: e = !parity_flag;
                        8'h99: e = !sign_flag;
                        8'h90: e = overflow_flag;
                        8'h9a: e = parity_flag;
                        8'h98: e = sign_flag;
                        default: continue;
                    endcase
                    send(`SSD_ESC_0F);
                    send(op);
                    send(8'hc0);
                    run(`SSD_K_SETCC, `SSD_CYC_1);
                    chk("set value", set_value_q, {7'h0, e});
                    chk("flag write", {7'h0, flags_write_q}, 8'h00);
                end
    endtask
    task t_tables;
        int m;
        for (m = 0; m < 2; m++) begin
            prot_mode = m[0];
            send(`SSD_ESC_0F);
            send(`SSD_OP_GRP_TBL);
            send(8'hc0);
            run(`SSD_K_STORE_GLOBAL_TABLE_REG, `SSD_CYC_4);
            chk("selector", {op_mod_q, op_reg_q, op_rm_q}, 8'hc0);
            send(`SSD_ESC_0F);
            send(`SSD_OP_GRP_TBL);
            send(8'hcb);
            run(`SSD_K_STORE_INTERRUPT_TABLE_REG, `SSD_CYC_4);
            chk("selector", {op_mod_q, op_reg_q, op_rm_q}, 8'hcb);
        end
        send(`SSD_ESC_0F);
        send(`SSD_OP_GRP_LDT);
        send(8'hc0);
        run(`SSD_K_STORE_LOCAL_TABLE_REG, `SSD_CYC_1);
        chk("flag write", {7'h0, flags_write_q}, 8'h00);
    endtask
    // Real-mode local table store, a set-byte with a bad subfield, a stray byte
    task t_bad;
        reg sb, ib;
        int i, j;
        prot_mode = 1'b0;
        for (j = 0; j < 3; j++) begin
            if (j < 2) send(`SSD_ESC_0F);
            send(j == 0 ? `SSD_OP_GRP_LDT : (j == 1 ? `SSD_OP_SET_GREATER : 8'h90));
            if (j < 2) send(j ? 8'hc8 : 8'hc0);
            byte_valid = 1'b0;
            sb = 1'b0;
            ib = 1'b0;
            for (i = 0; i < 5; i++) begin
                sb = sb | (op_start_q === 1'b1);
                ib = ib | (op_illegal_q === 1'b1);
                @(negedge clk_sys);
            end
            chk("refused", {7'h0, ib}, 8'h01);
            chk("no start", {7'h0, sb}, 8'h00);
        end
    endtask
    task t_shift;
        int s, f;
        reg [7:0] c;
        prot_mode = 1'b0;
        count_low_register = 8'h21;
        for (s = 0; s < 2; s++)
            for (f = 0; f < 3; f++) begin
                c = f == 0 ? 8'h01 : (f == 1 ? 8'h21 : 8'h06);
                send(f == 0 ? 8'hd1 : (f == 1 ? 8'hd3 : 8'hc1));
                send(s ? 8'he8 : 8'he0);
                if (f == 2) send(c);
                run(s ? `SSD_K_SHR : `SSD_K_SHL, f == 1 ? 6'h02 : 6'h01);
                chk("count", op_count_q, c);
                chk("ovf undef", {7'h0, overflow_undef_q}, {7'h0, f != 0});
                chk("aux undef", {7'h0, aux_carry_undef_q}, 8'h01);
                chk("flag write", {7'h0, flags_write_q}, 8'h01);
            end
    endtask
    task t_double;
        int j;
        reg [7:0] d;
        prot_mode = 1'b1;
        count_low_register = 8'h0b;
        for (j = 0; j < 4; j++) begin
            d = {4'ha, j[1], 2'b10, j[0]};
            send(`SSD_ESC_0F);
            send(d);
            send(8'hc1);
            if (!d[0]) send(8'hff);
            run(d[3] ? `SSD_K_DSHR : `SSD_K_DSHL, d[0] ? 6'h05 : 6'h04);
            chk("count", op_count_q, d[0] ? 8'h0b : 8'hff);
            chk("ovf undef", {7'h0, overflow_undef_q}, 8'h01);
            chk("aux undef", {7'h0, aux_carry_undef_q}, 8'h01);
            chk("flag write", {7'h0, flags_write_q}, 8'h01);
            chk("opcode", op_opcode_q, d);
            chk("selector", {op_mod_q, op_reg_q, op_rm_q}, 8'hc1);
            chk("wide", {7'h0, op_wide_q}, {7'h0, d[0]});
        end
    endtask
    task t_mgmt;
        int m;
        for (m = 0; m < 2; m++) begin
            prot_mode = m[0];
            send(`SSD_ESC_0F);
            send(`SSD_OP_SMM_ENTRY);
            run(`SSD_K_SMM, `SSD_CYC_55);
            chk("mgmt entry", {7'h0, mg0}, 8'h01);
            chk("mgmt end", {7'h0, mgmt_entry_q}, 8'h00);
        end
    endtask

    // ==========
    // Run control
    task stop_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        prot_mode = 1'b0;
        count_low_register = 8'h00;
        {overflow_flag, sign_flag, zero_flag, parity_flag} = 4'h0;
        mismatches = 0;
        compares = 0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_setcc;
        t_tables;
        t_bad;
        t_shift;
        t_double;
        t_mgmt;
        stop_test;
    end
endmodule // ssd_decoder_bench
